//--- verilog/command_sm.sv
// Command interpreter state machine of the reader, with its checks.

// Summary of operation
// - Command register starts command; FIFO carries data.
// - Wait for all arguments; never clear FIFO.
// - Code 3F is never accepted from host.
// - Power-on or pin falling edge starts power-up.
// - Power-up clears registers, then loads from memory.
// - Power-up ends by entering idle unaided.
// - During power-up only page 0 reads work.
// - Host writes cannot interrupt power-up.
// - Idle code 00 does nothing, waits.
// - Self-ending command enters idle, raises done flag.
// - Host idle abort raises no done flag.
// - Abort keeps FIFO contents.
// - Transmit 1A sends FIFO bytes, host start only.
// - Receive 16 waits interval, fills FIFO.
// - Transceive 1E transmits, then receives after wait.
// - Memory write 01: address low, high, data.
// - Memory read 03: address, count, bytes back.
// - Register load 07: address, then registers load.
// - Checksum 12 streams FIFO bytes to coprocessor.
module command_sm
	import cmd_sm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire host_cmd_t host_cmd,
	input wire logic host_rd,
	input wire logic [2:0] host_page,
	input wire logic hard_reset_powerdown_pin,
	input wire logic [7:0] receive_wait_count,
	input wire logic bit_tick,
	input wire fifo_in_t fifo_in,
	output fifo_out_t fifo_out,
	input wire logic tx_ready,
	output byte_t tx_out,
	input wire rx_in_t rx_in,
	output logic rx_on,
	input wire logic nvm_ready,
	input wire logic nvm_rvalid,
	input wire logic [7:0] nvm_rdata,
	input wire logic cfg_done,
	output nvm_out_t nvm_out,
	output byte_t crc_out,
	output logic [5:0] command_code,
	output logic command_done_irq,
	output logic host_access_ok
);

	// ****************************************************
	// Helper functions
	// ****************************************************
	function automatic logic in_power_up_init_cmd(input cmd_state_t s);
		in_power_up_init_cmd = (s == ST_POWER_UP_INIT_CMD_CLR) || (s == ST_POWER_UP_INIT_CMD_LOAD);
	endfunction : in_power_up_init_cmd

	// Codes that the host may launch; power-up is deliberately absent.
	function automatic logic host_code_ok(input logic [5:0] c);
		host_code_ok = (c == CMD_IDLE) || (c == CMD_NVM_WRITE) ||
			(c == CMD_NVM_READ) || (c == CMD_REG_LOAD) ||
			(c == CMD_CHECKSUM) || (c == CMD_RECEIVE) ||
			(c == CMD_TRANSMIT) || (c == CMD_TRANSCEIVE);
	endfunction : host_code_ok

	// Return to idle after a self-ending command.
	function automatic cmd_sm_t finish(input cmd_sm_t s);
		cmd_sm_t r;
		r = s;
		r.st = ST_IDLE;
		r.cmd = CMD_IDLE;
		r.irq = 1'b1;
		r.rx_on = 1'b0;
		r.nvm.load = 1'b0;
		finish = r;
	endfunction : finish

	// ****************************************************
	// State and receive-wait timer
	// ****************************************************
	cmd_sm_t q;
	cmd_sm_t d;
	logic wait_zero;
	logic [7:0] rbyte;
	logic [1:0] need;

	wait_counter u_wait (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.load(q.wait_load),
		.load_val(receive_wait_count),
		.tick(bit_tick),
		.zero(wait_zero)
	);

	assign rbyte = fifo_in.rdata;
	assign need = (q.cmd == CMD_NVM_READ) ? ARGS_ADDR_LEN : ARGS_ADDR;

	// Next state. Single-cycle strobes fall back to zero every cycle. A FIFO
	// byte is popped at the edge that ends the cycle with fo.rd high, so a new
	// pop waits one cycle for the level to follow.
	always_comb begin
		d = q;
		d.fo.rd = 1'b0;
		d.fo.wr = 1'b0;
		d.nvm.wr = 1'b0;
		d.nvm.rd = 1'b0;
		d.crc.valid = 1'b0;
		d.irq = 1'b0;
		d.wait_load = 1'b0;
		d.pin_prev = hard_reset_powerdown_pin;
		d.acc_ok = !in_power_up_init_cmd(q.st) ||
			(host_rd && (host_page == PAGE_CMD_STATUS));
		case (q.st)
			ST_POWER_UP_INIT_CMD_CLR: begin
				d.cnt = q.cnt + 8'h01;
				if (q.cnt == CLR_CYCLES - 8'h01) begin
					d.nvm.clear = 1'b0;
					d.nvm.load = 1'b1;
					d.nvm.addr = POWER_UP_INIT_CMD_FILE_ADDR;
					d.st = ST_POWER_UP_INIT_CMD_LOAD;
				end
			end
			ST_POWER_UP_INIT_CMD_LOAD: begin
				if (cfg_done) begin
					d = finish(d);
				end
			end
			ST_IDLE: begin
				d.st = ST_IDLE;
			end
			ST_ARGS: begin
				if (q.fo.rd) begin
					d.idx = q.idx + 2'h1;
					if (q.idx == 2'h0) begin
						d.addr[7:0] = rbyte;
					end else if (q.idx == 2'h1) begin
						d.addr[15:8] = rbyte;
					end else begin
						d.cnt = rbyte;
					end
					if (q.idx == need - 2'h1) begin
						if (q.cmd == CMD_NVM_WRITE) begin
							d.st = ST_NVM_WR;
						end else if (q.cmd == CMD_NVM_READ) begin
							d.st = ST_NVM_RD;
						end else begin
							d.st = ST_CFG;
							d.nvm.load = 1'b1;
							d.nvm.addr = {rbyte, q.addr[7:0]};
						end
					end
				end else if (q.idx == 2'h0) begin
					d.fo.rd = (fifo_in.level >= {5'h00, need});
				end else begin
					d.fo.rd = (fifo_in.level != FIFO_EMPTY);
				end
			end
			ST_NVM_WR: begin
				if (q.fo.rd) begin
					d.nvm.wr = 1'b1;
					d.nvm.wdata = rbyte;
					d.nvm.addr = q.addr;
					d.addr = q.addr + 16'h0001;
				end else if (!q.nvm.wr) begin
					if (fifo_in.level == FIFO_EMPTY) begin
						d = finish(d);
					end else if (nvm_ready) begin
						d.fo.rd = 1'b1;
					end
				end
			end
			ST_NVM_RD: begin
				if (nvm_rvalid && q.pend) begin
					d.fo.wr = 1'b1;
					d.fo.wdata = nvm_rdata;
					d.cnt = q.cnt - 8'h01;
					d.pend = 1'b0;
				end else if (!q.pend) begin
					if (q.cnt == 8'h00) begin
						d = finish(d);
					end else if (nvm_ready) begin
						d.nvm.rd = 1'b1;
						d.nvm.addr = q.addr;
						d.addr = q.addr + 16'h0001;
						d.pend = 1'b1;
					end
				end
			end
			ST_CFG: begin
				if (cfg_done) begin
					d = finish(d);
				end
			end
			ST_TX: begin
				if (q.tx.valid && tx_ready) begin
					d.tx.valid = 1'b0;
				end
				if (q.fo.rd) begin
					d.tx.valid = 1'b1;
					d.tx.data = rbyte;
					d.started = 1'b1;
				end else if (!q.tx.valid) begin
					if (fifo_in.level != FIFO_EMPTY) begin
						d.fo.rd = 1'b1;
					end else if (q.started && tx_ready) begin
						if (q.cmd == CMD_TRANSCEIVE) begin
							d.st = ST_RX_WAIT;
							d.wait_load = 1'b1;
						end else begin
							d = finish(d);
						end
					end
				end
			end
			ST_RX_WAIT: begin
				if (!q.wait_load && wait_zero) begin
					d.rx_on = 1'b1;
					d.st = ST_RX;
				end
			end
			ST_RX: begin
				if (rx_in.valid) begin
					d.fo.wr = 1'b1;
					d.fo.wdata = rx_in.data;
				end
				if (rx_in.done) begin
					d = finish(d);
				end
			end
			ST_CRC: begin
				if (q.fo.rd) begin
					d.crc.valid = 1'b1;
					d.crc.data = rbyte;
				end else if (fifo_in.level != FIFO_EMPTY) begin
					d.fo.rd = 1'b1;
				end else begin
					d = finish(d);
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
		if (host_cmd.wr && !in_power_up_init_cmd(q.st)) begin
			// no pops or pushes after abort
			d.irq = 1'b0;
			d.fo.rd = 1'b0;
			d.fo.wr = 1'b0;
			d.nvm.wr = 1'b0;
			d.nvm.rd = 1'b0;
			d.nvm.load = 1'b0;
			d.crc.valid = 1'b0;
			d.tx.valid = 1'b0;
			d.rx_on = 1'b0;
			d.pend = 1'b0;
			d.idx = 2'h0;
			d.started = 1'b0;
			d.cmd = host_cmd.code;
			if (!host_code_ok(host_cmd.code)) begin
				d.cmd = CMD_IDLE;
				d.st = ST_IDLE;
			end else if (host_cmd.code == CMD_IDLE) begin
				d.st = ST_IDLE;
			end else if (host_cmd.code == CMD_TRANSMIT ||
				host_cmd.code == CMD_TRANSCEIVE) begin
				d.st = ST_TX;
			end else if (host_cmd.code == CMD_RECEIVE) begin
				d.st = ST_RX_WAIT;
				d.wait_load = 1'b1;
			end else if (host_cmd.code == CMD_CHECKSUM) begin
				d.st = ST_CRC;
			end else begin
				d.st = ST_ARGS;
			end
		end
		if (q.pin_prev && !hard_reset_powerdown_pin) begin
			d = SM_RESET;
			d.pin_prev = 1'b0;
		end
	end

	// State register; power-on reset lands in the power-up command.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= SM_RESET;
		end else begin
			q <= d;
		end
	end

	// ****************************************************
	// Outputs, all taken from the state register
	// ****************************************************
	assign fifo_out = q.fo;
	assign tx_out = q.tx;
	assign rx_on = q.rx_on;
	assign nvm_out = q.nvm;
	assign crc_out = q.crc;
	assign command_code = q.cmd;
	assign command_done_irq = q.irq;
	assign host_access_ok = q.acc_ok;

	// ****************************************************
	// Checks
	// ****************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_host_abort;
		host_cmd.wr && (host_cmd.code == CMD_IDLE) &&
			(q.st != ST_IDLE) && !in_power_up_init_cmd(q.st) &&
			!(q.pin_prev && !hard_reset_powerdown_pin);
	endsequence

	sequence s_pin_fall;
		q.pin_prev && !hard_reset_powerdown_pin;
	endsequence

	chk_power_up_code: assert property (
		(q.st == ST_IDLE) && host_cmd.wr &&
			(host_cmd.code == CMD_POWER_UP) && !$fell(hard_reset_powerdown_pin)
			&& hard_reset_powerdown_pin
		|=> (q.st == ST_IDLE) && (q.cmd == CMD_IDLE))
		else $error("power-up code accepted from host");

	chk_pin_restart: assert property (
		s_pin_fall |=> (q.st == ST_POWER_UP_INIT_CMD_CLR) && q.nvm.clear &&
			(q.cmd == CMD_POWER_UP))
		else $error("pin edge did not restart power-up");

	chk_clear_then_load: assert property (
		s_pin_fall ##1 (hard_reset_powerdown_pin || !q.pin_prev)[*4]
		|=> $past(q.nvm.clear, 4) && $past(q.nvm.clear) &&
			!q.nvm.clear && q.nvm.load &&
			(q.nvm.addr == POWER_UP_INIT_CMD_FILE_ADDR))
		else $error("clear phase length or load start wrong");

	chk_power_up_init_cmd_done: assert property (
		(q.st == ST_POWER_UP_INIT_CMD_LOAD) && cfg_done &&
			hard_reset_powerdown_pin
		|=> (q.st == ST_IDLE) && command_done_irq && (q.cmd == CMD_IDLE))
		else $error("power-up did not end in idle with flag");

	chk_power_up_init_cmd_holds: assert property (
		(q.st == ST_POWER_UP_INIT_CMD_LOAD) && !cfg_done && hard_reset_powerdown_pin
		|=> (q.st == ST_POWER_UP_INIT_CMD_LOAD))
		else $error("power-up left early");

	chk_page_gate: assert property (
		in_power_up_init_cmd(q.st) && !(host_rd && (host_page == PAGE_CMD_STATUS))
		|=> !host_access_ok)
		else $error("access granted during power-up");

	chk_abort_quiet: assert property (
		s_host_abort |=> (q.st == ST_IDLE) && !command_done_irq ##1
			!command_done_irq)
		else $error("abort raised the done flag");

	chk_abort_fifo: assert property (
		s_host_abort |=> !fifo_out.rd && !fifo_out.wr)
		else $error("abort touched the FIFO");

	chk_args_wait: assert property (
		(q.st == ST_ARGS) && (q.idx == 2'h0) && !q.fo.rd &&
			(fifo_in.level < {5'h00, need}) && !host_cmd.wr
		|=> !fifo_out.rd)
		else $error("argument read before all arrived");

	chk_rx_after_wait: assert property (
		$rose(rx_on) |-> wait_zero && $past(q.st == ST_RX_WAIT))
		else $error("receiver enabled before wait elapsed");

	chk_tx_host_only: assert property (
		(q.st != ST_TX) ##1 (q.st == ST_TX)
		|-> $past(host_cmd.wr) && (q.cmd == CMD_TRANSMIT ||
			q.cmd == CMD_TRANSCEIVE))
		else $error("transmit entered without host write");

	chk_unknown_idle: assert property (
		host_cmd.wr && !host_code_ok(host_cmd.code) && !in_power_up_init_cmd(q.st) &&
			hard_reset_powerdown_pin
		|=> (q.st == ST_IDLE) && (command_code == CMD_IDLE))
		else $error("unknown code not treated as idle");

endmodule : command_sm

//--- verilog/cmd_sm_pkg.sv
// Shared codes, constants and carriers of the command state machine.
package cmd_sm_pkg;

	// ****************************************************
	// Command codes
	// ****************************************************
	localparam logic [5:0] CMD_IDLE = 6'h00;
	localparam logic [5:0] CMD_NVM_WRITE = 6'h01;
	localparam logic [5:0] CMD_NVM_READ = 6'h03;
	localparam logic [5:0] CMD_REG_LOAD = 6'h07;
	localparam logic [5:0] CMD_CHECKSUM = 6'h12;
	localparam logic [5:0] CMD_RECEIVE = 6'h16;
	localparam logic [5:0] CMD_TRANSMIT = 6'h1a;
	localparam logic [5:0] CMD_TRANSCEIVE = 6'h1e;
	localparam logic [5:0] CMD_POWER_UP = 6'h3f;

	// ****************************************************
	// Counts, offsets and argument sizes
	// ****************************************************
	// Cycles for which the register clear is held in the reset phase.
	localparam logic [7:0] CLR_CYCLES = 8'h04;
	// Start address of the power-up register file in the memory.
	localparam logic [15:0] POWER_UP_INIT_CMD_FILE_ADDR = 16'h0010;
	localparam logic [1:0] ARGS_ADDR = 2'h2;
	localparam logic [1:0] ARGS_ADDR_LEN = 2'h3;
	localparam logic [6:0] FIFO_EMPTY = 7'h00;
	localparam logic [2:0] PAGE_CMD_STATUS = 3'h0;

	// ****************************************************
	// Types
	// ****************************************************
	typedef enum logic [3:0] {
		ST_POWER_UP_INIT_CMD_CLR, ST_POWER_UP_INIT_CMD_LOAD, ST_IDLE, ST_ARGS, ST_TX,
		ST_RX_WAIT, ST_RX, ST_NVM_WR, ST_NVM_RD, ST_CFG, ST_CRC
	} cmd_state_t;

	typedef struct packed {logic wr; logic [5:0] code;} host_cmd_t;
	typedef struct packed {logic [6:0] level; logic [7:0] rdata;} fifo_in_t;
	typedef struct packed {logic rd; logic wr; logic [7:0] wdata;} fifo_out_t;
	typedef struct packed {logic valid; logic [7:0] data;} byte_t;
	typedef struct packed {logic valid; logic [7:0] data; logic done;} rx_in_t;
	typedef struct packed {
		logic wr; logic rd; logic load; logic clear;
		logic [15:0] addr; logic [7:0] wdata;
	} nvm_out_t;

	typedef struct packed {
		cmd_state_t st;
		logic [5:0] cmd;
		logic [1:0] idx;
		logic [7:0] cnt;
		logic [15:0] addr;
		logic pend;
		logic started;
		logic wait_load;
		logic rx_on;
		logic irq;
		logic acc_ok;
		logic pin_prev;
		fifo_out_t fo;
		byte_t tx;
		byte_t crc;
		nvm_out_t nvm;
	} cmd_sm_t;

	// Power-on state: the power-up command with the clear asserted.
	localparam cmd_sm_t SM_RESET = '{
		st: ST_POWER_UP_INIT_CMD_CLR, cmd: CMD_POWER_UP, idx: 2'h0, cnt: 8'h00,
		addr: 16'h0000, pend: 1'b0, started: 1'b0, wait_load: 1'b0,
		rx_on: 1'b0, irq: 1'b0, acc_ok: 1'b0, pin_prev: 1'b1,
		fo: '0, tx: '0, crc: '0,
		nvm: '{wr: 1'b0, rd: 1'b0, load: 1'b0, clear: 1'b1,
			addr: 16'h0000, wdata: 8'h00}
	};

endpackage : cmd_sm_pkg

//--- verilog/wait_counter.sv
// Loadable down counter that times the receive-wait interval in bit clocks.
module wait_counter
	import cmd_sm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [7:0] load_val,
	input wire logic tick,
	output logic zero
);

	typedef struct packed {logic [7:0] cnt; logic zero;} wait_t;

	wait_t q;
	wait_t d;

	// A load wins over a tick so a restart never inherits an old count.
	always_comb begin
		d = q;
		if (load) begin
			d.cnt = load_val;
			d.zero = (load_val == 8'h00);
		end else if (tick && !q.zero) begin
			d.cnt = q.cnt - 8'h01;
			d.zero = (q.cnt == 8'h01);
		end
	end

	// State register.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '{cnt: 8'h00, zero: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign zero = q.zero;

endmodule : wait_counter

//--- tb/fifo_model.sv
// Behavioural byte buffer standing at the far side of the command block.
module fifo_model
	import cmd_sm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic push,
	input wire logic [7:0] push_data,
	input wire fifo_out_t fo,
	output fifo_in_t fi
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************************
	// Storage
	// ****************************************************
	logic [7:0] mem [0:127];
	logic [6:0] rp_q;
	logic [6:0] wp_q;
	logic [7:0] last_q;

	// Contents kept on abort.
	// Host pushes land before block pushes in one cycle; both are kept.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rp_q <= 7'h00;
			wp_q <= 7'h00;
			last_q <= 8'h00;
		end else begin
			if (fo.rd && (wp_q != rp_q)) begin
				last_q <= mem[rp_q];
				rp_q <= rp_q + 7'h01;
			end
			if (push && fo.wr) begin
				mem[wp_q] <= push_data;
				mem[wp_q + 7'h01] <= fo.wdata;
				wp_q <= wp_q + 7'h02;
			end else if (push || fo.wr) begin
				mem[wp_q] <= push ? push_data : fo.wdata;
				wp_q <= wp_q + 7'h01;
			end
		end
	end

	// An empty buffer shows the inverse of the last byte, never a stale copy.
	always_comb begin
		fi.level = wp_q - rp_q;
		fi.rdata = (wp_q != rp_q) ? mem[rp_q] : ~last_q;
	end
endmodule : fifo_model

//--- tb/tb_command_sm.sv
// Self-checking testbench of the command state machine.
module tb_command_sm;
	import cmd_sm_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************************
	// Signals
	// ****************************************************
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	host_cmd_t host_cmd = '0;
	logic host_rd = 1'b0;
	logic [2:0] host_page = 3'h0;
	logic pin = 1'b1;
	logic nvm_rvalid = 1'b0;
	logic [7:0] nvm_rdata = 8'h00;
	logic cfg_done = 1'b0;
	logic push = 1'b0;
	logic [7:0] push_data = 8'h00;
	fifo_in_t fifo_in;
	fifo_out_t fifo_out;
	byte_t tx_out;
	byte_t crc_out;
	nvm_out_t nvm_out;
	logic rx_on;
	logic [5:0] command_code;
	logic command_done_irq;
	logic host_access_ok;
	int miscompares = 0;
	int total_checks = 0;
	logic [7:0] tx_seen [0:3];
	int tx_n = 0;
	rx_in_t rx_in = '0;
	logic [15:0] crc_log = 16'h0000;
	int crc_n = 0;
	logic [15:0] wr_log = 16'h0000;
	logic [15:0] wr_addr = 16'h0000;
	int wr_n = 0;

	// ****************************************************
	// Instances
	// ****************************************************
	command_sm i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .host_cmd(host_cmd),
		.host_rd(host_rd), .host_page(host_page),
		.hard_reset_powerdown_pin(pin), .receive_wait_count(8'h03),
		.bit_tick(1'b1), .fifo_in(fifo_in), .fifo_out(fifo_out),
		.tx_ready(1'b1), .tx_out(tx_out), .rx_in(rx_in), .rx_on(rx_on),
		.nvm_ready(1'b1), .nvm_rvalid(nvm_rvalid), .nvm_rdata(nvm_rdata),
		.cfg_done(cfg_done), .nvm_out(nvm_out), .crc_out(crc_out),
		.command_code(command_code), .command_done_irq(command_done_irq),
		.host_access_ok(host_access_ok));
	fifo_model i_fifo (.sys_clk(sys_clk), .rst_b(rst_b), .push(push),
		.push_data(push_data), .fo(fifo_out), .fi(fifo_in));

	// Clock of 8 ns period.
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end

	// Bytes handed to transmitter, checksum unit and memory, in order.
	// Sampled mid-cycle so that a one-cycle strobe is seen exactly once.
	always @(negedge sys_clk) begin
		if (tx_out.valid === 1'b1 && tx_n < 4) begin
			tx_seen[tx_n] = tx_out.data;
			tx_n = tx_n + 1;
		end
		if (crc_out.valid === 1'b1) begin
			crc_log = {crc_log[7:0], crc_out.data};
			crc_n = crc_n + 1;
		end
		if (nvm_out.wr === 1'b1) begin
			wr_log = {wr_log[7:0], nvm_out.wdata};
			wr_addr = nvm_out.addr;
			wr_n = wr_n + 1;
		end
	end

	// ****************************************************
	// Shared tasks
	// ****************************************************
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step

	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wr_cmd(input logic [5:0] code);
		host_cmd = '{wr: 1'b1, code: code};
		step(1);
		host_cmd.wr = 1'b0;
		step(1);
	endtask : wr_cmd

	task put(input logic [7:0] b);
		push = 1'b1;
		push_data = b;
		step(1);
		push = 1'b0;
		step(1);
	endtask : put

	// Waits a bounded time for the done pulse and reports whether it came.
	task wait_irq(input logic exp);
		int i;
		for (i = 0; i < 300 && command_done_irq !== 1'b1; i++) step(1);
		chk(command_done_irq, exp);
	endtask : wait_irq

	// Runs the power-up load phase to its end, pulsing the load-done input.
	task finish_power_up;
		int i;
		for (i = 0; i < 50 && nvm_out.load !== 1'b1; i++) step(1);
		chk({nvm_out.load, nvm_out.clear}, 16'h0002);
		chk(nvm_out.addr, POWER_UP_INIT_CMD_FILE_ADDR);
		cfg_done = 1'b1;
		step(1);
		// host polls for idle code first.
		chk(command_code, CMD_IDLE);
		chk(command_done_irq, 1'b1);
		cfg_done = 1'b0;
		step(2);
		chk(host_access_ok, 1'b1);
	endtask : finish_power_up

	task complete_run;
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	// ****************************************************
	// Scenarios
	// ****************************************************
	task test_power_up;
		chk(command_code, CMD_POWER_UP);
		chk(nvm_out.clear, 1'b1);
		rst_b = 1'b1;
		step(1);
		wr_cmd(CMD_TRANSMIT);
		chk(command_code, CMD_POWER_UP);
		host_rd = 1'b1;
		step(2);
		chk(host_access_ok, 1'b1);
		host_page = 3'h2;
		step(2);
		chk(host_access_ok, 1'b0);
		host_rd = 1'b0;
		finish_power_up();
		$display("test power-up done");
	endtask : test_power_up

	task test_transmit;
		put(8'ha5);
		put(8'h3c);
		wr_cmd(CMD_TRANSMIT);
		wait_irq(1'b1);
		chk(command_code, CMD_IDLE);
		chk(tx_n, 2);
		chk({tx_seen[0], tx_seen[1]}, 16'ha53c);
		$display("test transmit done");
	endtask : test_transmit

	task test_codes;
		wr_cmd(CMD_POWER_UP);
		chk(command_code, CMD_IDLE);
		wr_cmd(6'h2b);
		chk(command_code, CMD_IDLE);
		step(5);
		chk(tx_n, 2);
		$display("test codes done");
	endtask : test_codes

	task test_abort;
		put(8'h34);
		wr_cmd(CMD_REG_LOAD);
		step(4);
		chk(command_code, CMD_REG_LOAD);
		chk(nvm_out.load, 1'b0);
		wr_cmd(CMD_IDLE);
		chk(command_code, CMD_IDLE);
		wait_irq(1'b0);
		chk(fifo_in.level, 7'h01);
		$display("test abort done");
	endtask : test_abort

	// The byte left behind by the abort is the address low byte here.
	task test_nvm_read;
		int i;
		put(8'h12);
		put(8'h01);
		wr_cmd(CMD_NVM_READ);
		for (i = 0; i < 50 && nvm_out.rd !== 1'b1; i++) step(1);
		chk(nvm_out.addr, 16'h1234);
		step(2);
		nvm_rvalid = 1'b1;
		nvm_rdata = 8'hc3;
		step(1);
		nvm_rvalid = 1'b0;
		wait_irq(1'b1);
		step(1);
		chk({fifo_in.level, fifo_in.rdata}, 16'h01c3);
		$display("test memory read done");
	endtask : test_nvm_read

	// The byte returned by the memory read is streamed first.
	task test_checksum;
		put(8'h11);
		wr_cmd(CMD_CHECKSUM);
		wait_irq(1'b1);
		chk(crc_n, 2);
		chk(crc_log, 16'hc311);
		chk(fifo_in.level, 7'h00);
		$display("test checksum done");
	endtask : test_checksum

	task test_nvm_write;
		put(8'h40);
		put(8'h00);
		put(8'haa);
		put(8'hbb);
		wr_cmd(CMD_NVM_WRITE);
		wait_irq(1'b1);
		chk(wr_n, 2);
		chk(wr_log, 16'haabb);
		chk(wr_addr, 16'h0041);
		$display("test memory write done");
	endtask : test_nvm_write

	task test_reg_load;
		int i;
		put(8'h80);
		put(8'h01);
		wr_cmd(CMD_REG_LOAD);
		for (i = 0; i < 50 && nvm_out.load !== 1'b1; i++) step(1);
		chk(nvm_out.addr, 16'h0180);
		chk(fifo_in.level, 7'h00);
		cfg_done = 1'b1;
		step(1);
		chk(command_done_irq, 1'b1);
		chk(nvm_out.load, 1'b0);
		chk(command_code, CMD_IDLE);
		cfg_done = 1'b0;
		step(1);
		$display("test register load done");
	endtask : test_reg_load

	// With a wait count of 3 and a tick every cycle the receiver comes on
	// five cycles after the command write.
	task test_receive;
		wr_cmd(CMD_RECEIVE);
		step(3);
		chk(rx_on, 1'b0);
		step(1);
		chk(rx_on, 1'b1);
		rx_in = '{valid: 1'b1, data: 8'h5e, done: 1'b0};
		step(1);
		rx_in = '{valid: 1'b0, data: 8'h00, done: 1'b1};
		step(1);
		rx_in = '0;
		chk(command_done_irq, 1'b1);
		chk(rx_on, 1'b0);
		chk({fifo_in.level, fifo_in.rdata}, 16'h015e);
		$display("test receive done");
	endtask : test_receive

	// The received byte still in the buffer is transmitted first.
	task test_transceive;
		int i;
		put(8'hc5);
		wr_cmd(CMD_TRANSCEIVE);
		for (i = 0; i < 50 && rx_on !== 1'b1; i++) step(1);
		chk(command_code, CMD_TRANSCEIVE);
		chk(tx_n, 4);
		chk({tx_seen[2], tx_seen[3]}, 16'h5ec5);
		chk(fifo_in.level, 7'h00);
		rx_in.done = 1'b1;
		step(1);
		rx_in.done = 1'b0;
		chk(command_done_irq, 1'b1);
		chk(command_code, CMD_IDLE);
		$display("test transceive done");
	endtask : test_transceive

	task test_pin;
		pin = 1'b0;
		step(3);
		chk(command_code, CMD_POWER_UP);
		pin = 1'b1;
		finish_power_up();
		$display("test hard reset done");
	endtask : test_pin

	// ****************************************************
	// Main sequence and watchdog
	// ****************************************************
	initial begin
		step(10);
		test_power_up();
		test_transmit();
		test_codes();
		test_abort();
		test_nvm_read();
		test_checksum();
		test_nvm_write();
		test_reg_load();
		test_receive();
		test_transceive();
		test_pin();
		complete_run();
	end

	initial begin
		#100us;
		miscompares++;
		complete_run();
	end
endmodule : tb_command_sm
